// >>> pkg/imb_pkg.sv
// Purpose: Shared constants and types for the two-wire master sequencer.
// Assumes: Registers sit on a small word port with a 2-bit address.
// Notes:   Offsets, field positions, reset values and last step indices live here.
package imb_pkg;
  // Register word offsets
  localparam logic [1:0] IMB_OFF_CTRL   = 2'h0;
  localparam logic [1:0] IMB_OFF_RELOAD = 2'h1;
  localparam logic [1:0] IMB_OFF_BUF    = 2'h2;
  localparam logic [1:0] IMB_OFF_STAT   = 2'h3;
  // Control register field positions
  localparam int IMB_B_GENERAL_CALL_ACCEPT  = 7;
  localparam int IMB_B_ACKST = 6;
  localparam int IMB_B_ACK_VALUE_TO_SEND = 5;
  localparam int IMB_B_ACKGO = 4;
  localparam int IMB_B_RXGO  = 3;
  localparam int IMB_B_SPGO  = 2;
  localparam int IMB_B_RSGO  = 1;
  localparam int IMB_B_STGO  = 0;
  // Status register field positions
  localparam int IMB_S_BUSY  = 0;
  localparam int IMB_S_AVAIL = 1;
  localparam int IMB_S_FULL  = 2;
  // Reset values
  localparam logic [7:0] IMB_CTRL_RST   = 8'h00;
  localparam logic [7:0] IMB_RELOAD_RST = 8'h00;
  // Widths and depths
  localparam int IMB_DATA_W   = 8;
  localparam int IMB_RELOAD_W = 7;
  localparam int IMB_FIFO_D   = 16;
  // Last step index of each sequence, then the receive push step and the ack bit index; one step per generator rollover
  localparam logic [4:0] IMB_LAST_ST = 5'h01;
  localparam logic [4:0] IMB_LAST_RS = 5'h03;
  localparam logic [4:0] IMB_LAST_SP = 5'h02;
  localparam logic [4:0] IMB_LAST_TX = 5'h12;
  localparam logic [4:0] IMB_LAST_RX = 5'h10;
  localparam logic [4:0] IMB_LAST_AK = 5'h02;
  localparam logic [4:0] IMB_RX_PUSH = 5'h0F;
  localparam logic [3:0] IMB_ACK_BIT = 4'h8;
  // Sequencer states
  typedef enum logic [2:0] {
    IMB_IDLE, IMB_START, IMB_RSTART, IMB_STOP, IMB_TX, IMB_RX, IMB_ACK
  } imb_seq_t;
endpackage : imb_pkg

// >>> hw/imb_i2c_master.sv
// Purpose: Two-wire bus master sequencer with reload rate generator.
// Assumes: Open-drain pins; output enable low means pulling the line low.
// Notes:   Received bytes queue in a 16-word FIFO read through the buffer.
`timescale 1ns/1ns

// Plain FIFO with valid/ready on both sides
module imb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];      // Storage words
  logic [AW-1:0] wp_q;         // Write pointer
  logic [AW-1:0] rp_q;         // Read pointer
  logic [AW:0]   cnt_q;        // Fill level
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + AW'(1);
      end
      if (pop) begin
        rp_q <= rp_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : imb_fifo

// Master sequencer top
module imb_i2c_master (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       serial_clock_line_in,
  output logic            serial_clock_line_out,
  output logic            serial_clock_line_oe_n,
  input  wire logic       serial_data_line_in,
  output logic            serial_data_line_out,
  output logic            serial_data_line_oe_n
);
  imb_pkg::imb_seq_t st_q;            // Sequencer state
  logic [4:0] step_q;                 // Half-bit step index
  logic [1:0] ph_q;                   // Instruction cycle phase
  logic       tick;                   // Generator decrement strobe
  logic [6:0] cnt_q;                  // Rate generator count
  logic       run_q;                  // Rate generator running
  logic       roll;                   // Generator rollover
  logic       busy;                   // Sequence in progress
  logic       done;                   // Last step finished
  logic [7:0] reload_q;               // Reload/address register
  logic       general_call_accept_q;                 // General call accept, unused
  logic       ack_value_to_send_q;                // Ack value to send
  logic       ackst_q;                // Ack received flag
  logic [4:0] go_q;                   // Sequence go bits
  logic [4:0] go_sel;                 // Lowest requested go bit
  logic       wr_ctrl;
  logic       wr_buf;
  logic       rd_buf;
  logic       start_c;                // Condition, receive or ack start
  logic       tx_start;               // Byte transmit start
  logic       start;
  logic [7:0] sh_q;                   // Transmit shifter
  logic [7:0] rx_q;                   // Receive shifter
  logic       push_q;                 // Received byte ready
  logic       scl_s1_q, scl_s2_q;     // Clock pin synchroniser
  logic       sda_s1_q, sda_s2_q;     // Data pin synchroniser
  logic       scl_low_q, sda_low_q;   // Pin pull-down state
  logic       scl_w, sda_w;           // Wanted pull-downs
  logic [3:0] bit_idx;
  logic       fifo_ready, fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] rdata_q;

  // Last step index of each sequence
  function automatic logic [4:0] last_step(input imb_pkg::imb_seq_t s);
    case (s)
      imb_pkg::IMB_START:  last_step = imb_pkg::IMB_LAST_ST;
      imb_pkg::IMB_RSTART: last_step = imb_pkg::IMB_LAST_RS;
      imb_pkg::IMB_STOP:   last_step = imb_pkg::IMB_LAST_SP;
      imb_pkg::IMB_TX:     last_step = imb_pkg::IMB_LAST_TX;
      imb_pkg::IMB_RX:     last_step = imb_pkg::IMB_LAST_RX;
      imb_pkg::IMB_ACK:    last_step = imb_pkg::IMB_LAST_AK;
      default:             last_step = 5'h00;
    endcase
  endfunction : last_step

  assign busy     = (st_q != imb_pkg::IMB_IDLE);
  assign bit_idx  = step_q[4:1];
  assign wr_ctrl  = reg_wr & (reg_addr == imb_pkg::IMB_OFF_CTRL);
  assign wr_buf   = reg_wr & (reg_addr == imb_pkg::IMB_OFF_BUF);
  assign rd_buf   = reg_rd & (reg_addr == imb_pkg::IMB_OFF_BUF);
  assign go_sel   = reg_wdata[4:0] & 5'(~reg_wdata[4:0] + 5'h01);
  assign start_c  = wr_ctrl & ~busy & (go_sel != 5'h00)
                  & ~(go_sel[imb_pkg::IMB_B_RXGO] & ~fifo_ready);
  assign tx_start = wr_buf & ~busy;
  assign start    = start_c | tx_start;
  assign done     = roll & busy & (step_q == last_step(st_q));

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= serial_clock_line_in;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= serial_data_line_in;
      sda_s2_q <= sda_s1_q;
    end
  end

  // phases counted from the system clock
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end
  // decrement on phases two and four
  assign tick = ph_q[0];

  // rollover on the tick after zero, reload costs one tick
  assign roll = run_q & tick & (cnt_q == 7'h00);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q <= 7'h00;
      run_q <= 1'b0;
    end else if (start) begin
      // load low seven bits, begin counting
      cnt_q <= reload_q[imb_pkg::IMB_RELOAD_W-1:0];
      run_q <= 1'b1;
    end else if (roll) begin
      if (!done) begin
        cnt_q <= reload_q[imb_pkg::IMB_RELOAD_W-1:0];
      end else begin
        run_q <= 1'b0;
      end
    end else if (tick && cnt_q != 7'h00) begin
      cnt_q <= cnt_q - 7'h01;
    end
  end

  // Reload register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reload_q <= imb_pkg::IMB_RELOAD_RST;
    end else if (reg_wr && reg_addr == imb_pkg::IMB_OFF_RELOAD) begin
      reload_q <= reg_wdata;
    end
  end

  // Control register fields
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      general_call_accept_q  <= imb_pkg::IMB_CTRL_RST[imb_pkg::IMB_B_GENERAL_CALL_ACCEPT];
      ack_value_to_send_q <= imb_pkg::IMB_CTRL_RST[imb_pkg::IMB_B_ACK_VALUE_TO_SEND];
      go_q    <= imb_pkg::IMB_CTRL_RST[4:0];
    end else begin
      // general call bit stored, no master effect
      if (wr_ctrl) begin
        general_call_accept_q  <= reg_wdata[imb_pkg::IMB_B_GENERAL_CALL_ACCEPT];
        ack_value_to_send_q <= reg_wdata[imb_pkg::IMB_B_ACK_VALUE_TO_SEND];
      end
      if (done) begin
        go_q <= 5'h00;
      end else if (start_c) begin
        go_q <= go_sel;
      end
    end
  end

  // Sequencer state and step
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q   <= imb_pkg::IMB_IDLE;
      step_q <= 5'h00;
    end else if (tx_start) begin
      st_q   <= imb_pkg::IMB_TX;
      step_q <= 5'h00;
    end else if (start_c) begin
      step_q <= 5'h00;
      // One go bit chosen, lowest first
      if (go_sel[imb_pkg::IMB_B_STGO]) begin
        st_q <= imb_pkg::IMB_START;
      end else if (go_sel[imb_pkg::IMB_B_RSGO]) begin
        st_q <= imb_pkg::IMB_RSTART;
      end else if (go_sel[imb_pkg::IMB_B_SPGO]) begin
        st_q <= imb_pkg::IMB_STOP;
      end else if (go_sel[imb_pkg::IMB_B_RXGO]) begin
        st_q <= imb_pkg::IMB_RX;
      end else begin
        st_q <= imb_pkg::IMB_ACK;
      end
    end else if (done) begin
      st_q   <= imb_pkg::IMB_IDLE;
      step_q <= 5'h00;
    end else if (roll && busy) begin
      step_q <= step_q + 5'h01;
    end
  end

  // Wanted line levels per step
  always_comb begin
    scl_w = scl_low_q;
    sda_w = sda_low_q;
    case (st_q)
      // start, data falls while clock high
      imb_pkg::IMB_START: begin
        sda_w = 1'b1;
        scl_w = (step_q != 5'h00);
      end
      // restart, release both, then data falls
      imb_pkg::IMB_RSTART: begin
        sda_w = step_q[1];
        scl_w = (step_q != 5'h01) && (step_q != 5'h02);
      end
      // stop, data rises while clock high
      imb_pkg::IMB_STOP: begin
        sda_w = (step_q != imb_pkg::IMB_LAST_SP);
        scl_w = (step_q == 5'h00);
      end
      // each half clock period is one rollover
      imb_pkg::IMB_TX: begin
        scl_w = ~step_q[0] | (step_q == imb_pkg::IMB_LAST_TX);
        sda_w = (bit_idx < imb_pkg::IMB_ACK_BIT) ? ~sh_q[7] : 1'b0;
      end
      imb_pkg::IMB_RX: begin
        scl_w = ~step_q[0];
        sda_w = 1'b0;
      end
      imb_pkg::IMB_ACK: begin
        scl_w = ~step_q[0];
        sda_w = (step_q == imb_pkg::IMB_LAST_AK) ? 1'b0 : ~ack_value_to_send_q;
      end
      default: begin
        scl_w = scl_low_q;
        sda_w = sda_low_q;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (busy) begin
      scl_low_q <= scl_w;
      sda_low_q <= sda_w;
    end
  end

  // Shifters and ack capture at end of high half
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sh_q    <= 8'h00;
      rx_q    <= 8'h00;
      ackst_q <= 1'b0;
      push_q  <= 1'b0;
    end else begin
      push_q <= 1'b0;
      if (tx_start) begin
        sh_q <= reg_wdata;
      end else if (roll && st_q == imb_pkg::IMB_TX && step_q[0]) begin
        if (bit_idx < imb_pkg::IMB_ACK_BIT) begin
          sh_q <= {sh_q[6:0], 1'b0};
        end else begin
          ackst_q <= sda_s2_q;
        end
      end
      if (roll && st_q == imb_pkg::IMB_RX && step_q[0]) begin
        rx_q <= {rx_q[6:0], sda_s2_q};
        push_q <= (step_q == imb_pkg::IMB_RX_PUSH);
      end
    end
  end

  // Receive queue, drained by buffer reads
  imb_fifo #(
    .W (imb_pkg::IMB_DATA_W),
    .D (imb_pkg::IMB_FIFO_D)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (push_q),
    .in_ready  (fifo_ready),
    .in_data   (rx_q),
    .out_valid (fifo_valid),
    .out_ready (rd_buf),
    .out_data  (fifo_data)
  );

  // Read data, one cycle after strobe
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        imb_pkg::IMB_OFF_CTRL:   rdata_q <= {general_call_accept_q, ackst_q, ack_value_to_send_q, go_q};
        imb_pkg::IMB_OFF_RELOAD: rdata_q <= reload_q;
        imb_pkg::IMB_OFF_BUF:    rdata_q <= fifo_valid ? fifo_data : 8'h00;
        default:                 rdata_q <= {5'h00, ~fifo_ready, fifo_valid, busy};
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata              = rdata_q;
  assign serial_clock_line_out  = 1'b0;
  assign serial_data_line_out   = 1'b0;
  assign serial_clock_line_oe_n = ~scl_low_q;
  assign serial_data_line_oe_n  = ~sda_low_q;

  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_reload_low_bits: assert property (start |=> cnt_q == $past(reload_q[6:0]))
    else $error("generator not loaded from low reload bits");
  chk_write_starts_gen: assert property (tx_start |=> run_q && busy)
    else $error("buffer write did not start generator");
  chk_halt_at_zero: assert property (!run_q && !start |=> $stable(cnt_q) && !run_q)
    else $error("halted generator moved");
  chk_tick_alternate: assert property (tick |=> !tick ##1 tick)
    else $error("tick not on alternate cycles");
  chk_auto_reload: assert property (roll && !done |=> cnt_q == $past(reload_q[6:0]))
    else $error("generator not reloaded");
  chk_idle_pins_hold: assert property (!busy && !start |=> $stable(scl_low_q))
    else $error("clock line moved while idle");
  chk_go_self_clear: assert property (done |=> go_q == 5'h00 && !busy)
    else $error("go bits not cleared on completion");
  chk_busy_refuse: assert property (busy && !done && reg_wr |=> $stable(go_q)
                                    && $stable(st_q))
    else $error("command accepted while busy");
  chk_ack_capture: assert property (roll && st_q == imb_pkg::IMB_TX
                                    && step_q == 5'h11 |=> ackst_q == $past(sda_s2_q))
    else $error("slave ack not captured");
  chk_rx_one_byte: assert property (push_q |-> busy ##1 !push_q)
    else $error("receive pushed more than one byte");
  chk_start_edge: assert property (start_c && go_sel[0] |=> st_q == imb_pkg::IMB_START)
    else $error("start go did not start condition");
  chk_stop_data_last: assert property (st_q == imb_pkg::IMB_STOP && step_q == 5'h01
                                       |-> sda_w && !scl_w)
    else $error("stop released data before clock");

  cov_start_done: cover property (st_q == imb_pkg::IMB_START && done);
  cov_tx_done: cover property (st_q == imb_pkg::IMB_TX && done);
  cov_rx_push: cover property (push_q);
  cov_stop_done: cover property (st_q == imb_pkg::IMB_STOP && done);
endmodule : imb_i2c_master

// >>> tb/imb_slave_model.sv
// Purpose: Behavioural two-wire slave facing the master sequencer.
// Assumes: Both lines are open drain; the bench resolves the pull-ups.
// Notes:   Counts clock falls from the last start; no clock stretching.
`timescale 1ns/1ns
module imb_slave_model (
  input  wire logic       scl,      // Resolved clock line
  input  wire logic       sda,      // Resolved data line
  input  wire logic       ack_en,   // Acknowledge a written byte
  input  wire logic       rd_mode,  // Send tx_byte instead of taking one
  input  wire logic [7:0] tx_byte,  // Byte sent in read mode
  output logic            sda_pull, // High pulls the data line low
  output logic [7:0]      rx_byte,  // Bits seen on clock rises
  output logic            ack_bit   // Data level at the ninth rise
);
  int fall_cnt; // Clock falls since the last start

  // Quiet at time zero
  initial begin
    fall_cnt = 0;
    sda_pull = 1'b0;
    rx_byte  = 8'h00;
    ack_bit  = 1'b0;
  end

  // Start seen while clock is high restarts the count
  // Data may move in the same step as a clock fall; look again a bit later
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1) fall_cnt = 0;
  end

  // Sample data and the ninth-bit ack level on clock rise
  always @(posedge scl) begin
    if (fall_cnt >= 1 && fall_cnt <= 8) rx_byte = {rx_byte[6:0], sda};
    if (fall_cnt == 9) ack_bit = sda;
  end

  always @(negedge scl) begin
    fall_cnt = fall_cnt + 1;
    if (rd_mode) sda_pull = (fall_cnt <= 8) && !tx_byte[8 - fall_cnt];
    else sda_pull = (fall_cnt == 9) && ack_en;
  end
endmodule : imb_slave_model

// >>> tb/test_imb_i2c_master.sv
// Purpose: Register-level bench for the two-wire master sequencer.
// Assumes: Slave model acknowledges or sends bytes; lines pulled up.
// Notes:   Reload of three keeps every step after the first at eight clocks.
`timescale 1ns/1ns
module test_imb_i2c_master;
  localparam int RLD = 3; // Reload value used throughout
  logic       mclk;       // System clock
  logic       resetn;     // Synchronous reset
  logic [1:0] reg_addr;   // Register index
  logic [7:0] reg_wdata;  // Write data
  logic       reg_wr;     // Write strobe
  logic       reg_rd;     // Read strobe
  logic [7:0] reg_rdata;  // Read data
  logic       scl_oe_n;   // Clock pull, active low
  logic       sda_oe_n;   // Data pull, active low
  logic       ack_en;     // Slave acknowledges writes
  logic       rd_mode;    // Slave sends data
  logic [7:0] tx_byte;    // Byte from the slave
  logic [7:0] rx_byte;    // Byte seen by the slave
  logic       sda_pull;   // Slave pulls data low
  logic       ack_bit;    // Ninth bit seen by the slave
  wire logic  scl_w;      // Resolved clock line
  wire logic  sda_w;      // Resolved data line
  int         fail_count; // Mismatches
  int         n_checks;   // Comparisons
  int         cyc;        // Cycle counter for the timeout
  logic [7:0] d;          // Scratch read value
  time        t0;         // Edge time stamp

  // Open drain with pull-ups
  assign scl_w = scl_oe_n;
  assign sda_w = sda_oe_n & ~sda_pull;

  imb_i2c_master uut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_clock_line_in(scl_w), .serial_clock_line_out(),
    .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_in(sda_w),
    .serial_data_line_out(), .serial_data_line_oe_n(sda_oe_n)
  );

  imb_slave_model slave (
    .scl(scl_w), .sda(sda_w), .ack_en(ack_en), .rd_mode(rd_mode),
    .tx_byte(tx_byte), .sda_pull(sda_pull), .rx_byte(rx_byte), .ack_bit(ack_bit)
  );

  always #10 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end

  // One-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // Compare one byte
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Read and compare
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, exp, v);
  endtask : rchk

  // Poll busy with a bound
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      rd(imb_pkg::IMB_OFF_STAT, d);
      k++;
    end while (d[imb_pkg::IMB_S_BUSY] !== 1'b0 && k < 1000);
    if (k >= 1000) begin
      fail_count++;
      $display("[ERR] busy expected 0 seen %h", d);
    end
  endtask : wait_idle

  // Counts and verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ack_en = 1'b1;
    rd_mode = 1'b0;
    tx_byte = 8'h00;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    rchk(imb_pkg::IMB_OFF_CTRL, 8'h00, "ctrl reset");
    rchk(imb_pkg::IMB_OFF_RELOAD, 8'h00, "reload reset");
    rchk(imb_pkg::IMB_OFF_STAT, 8'h00, "status reset");
    rchk(imb_pkg::IMB_OFF_BUF, 8'h00, "empty buffer");
    $display("test reset done");
    // Top reload bit set, only low seven bits count
    wr(imb_pkg::IMB_OFF_RELOAD, 8'h80 | 8'(RLD));
    wr(imb_pkg::IMB_OFF_CTRL, 8'h05);
    rchk(imb_pkg::IMB_OFF_CTRL, 8'h01, "start pending");
    wr(imb_pkg::IMB_OFF_CTRL, 8'h04);
    rchk(imb_pkg::IMB_OFF_CTRL, 8'h01, "stop refused");
    wait_idle();
    rchk(imb_pkg::IMB_OFF_CTRL, 8'h00, "start cleared");
    chk("start lines", 8'h00, {6'h00, scl_w, sda_w});
    $display("test start done");
    wr(imb_pkg::IMB_OFF_BUF, 8'hA5);
    rchk(imb_pkg::IMB_OFF_STAT, 8'h01, "busy after write");
    @(posedge scl_w);
    @(posedge scl_w);
    t0 = $time;
    @(posedge scl_w);
    chk("clock period", 8'(4 * RLD + 4), 8'(($time - t0) / 20));
    wait_idle();
    chk("byte on wire", 8'hA5, rx_byte);
    rchk(imb_pkg::IMB_OFF_CTRL, 8'h00, "ack flag");
    chk("lines after", 8'h01, {6'h00, scl_w, sda_w});
    repeat (40) @(posedge mclk);
    chk("lines held", 8'h01, {6'h00, scl_w, sda_w});
    ack_en = 1'b0;
    wr(imb_pkg::IMB_OFF_BUF, 8'h5A);
    wait_idle();
    rchk(imb_pkg::IMB_OFF_CTRL, 8'h40, "nack flag");
    $display("test transmit done");
    rd_mode = 1'b1;
    for (int i = 0; i < 16; i++) begin
      tx_byte = 8'h30 + 8'(i);
      wr(imb_pkg::IMB_OFF_CTRL, 8'h02);
      wait_idle();
      wr(imb_pkg::IMB_OFF_CTRL, 8'h08);
      wait_idle();
      if (i == 0) begin
        wr(imb_pkg::IMB_OFF_CTRL, 8'h30);
        wait_idle();
        chk("ack sent", 8'h01, {7'h00, ack_bit});
        rd(imb_pkg::IMB_OFF_CTRL, d);
        chk("ack go clear", 8'h20, d & 8'h3F);
      end
    end
    rchk(imb_pkg::IMB_OFF_STAT, 8'h06, "fifo full");
    wr(imb_pkg::IMB_OFF_CTRL, 8'h08);
    rd(imb_pkg::IMB_OFF_CTRL, d);
    chk("receive refused", 8'h00, d & 8'h08);
    rchk(imb_pkg::IMB_OFF_STAT, 8'h06, "still idle");
    for (int i = 0; i < 16; i++) begin
      rchk(imb_pkg::IMB_OFF_BUF, 8'h30 + 8'(i), "fifo word");
    end
    rchk(imb_pkg::IMB_OFF_STAT, 8'h00, "fifo drained");
    $display("test receive done");
    rd_mode = 1'b0;
    wr(imb_pkg::IMB_OFF_CTRL, 8'h04);
    wait_idle();
    rchk(imb_pkg::IMB_OFF_CTRL, 8'h40, "stop cleared");
    chk("stop lines", 8'h03, {6'h00, scl_w, sda_w});
    $display("test stop done");
    conclude();
  end
endmodule : test_imb_i2c_master
